// file: hw/keypad_lock_control.v
`timescale 1ns/10ps
`include "keylock_consts.vh"

module keypad_lock_control #(
    parameter CYCLES_PER_SEC = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire evt_valid,
    input wire [6:0] evt_code,
    input wire evt_state,
    output reg irq_q,
    output reg locked_q
);

    // ****************************************************************
    // lock states
    // ****************************************************************
    localparam [1:0] S_OPEN = 2'h0;
    localparam [1:0] S_LOCKED = 2'h1;
    localparam [1:0] S_WAIT2 = 2'h2;

    reg [1:0] state_q, state_d;

    // ****************************************************************
    // registers
    // ****************************************************************
    reg [7:0] unlock_first_q, unlock_second_q, ext_trigger_q, lock_timing_q;
    reg [`ST_W-1:0] status_q, status_d, status_set, mask_q;

    // write address and data are held until both are in
    reg aw_hold_q, w_hold_q, wr_lane_q;
    reg [9:0] wr_idx_q;
    reg [7:0] wr_byte_q;

    wire tick, hold_run, win_run, win_exp;

    // ****************************************************************
    // event matching
    // ****************************************************************
    wire [6:0] first_key_code = unlock_first_q[`CODE_MSB:0];
    wire first_key_level = unlock_first_q[`LEVEL_BIT];
    wire [6:0] second_key_code = unlock_second_q[`CODE_MSB:0];
    wire second_key_level = unlock_second_q[`LEVEL_BIT];
    wire [6:0] guard_trigger_code = ext_trigger_q[`CODE_MSB:0];
    wire guard_trigger_level = ext_trigger_q[`LEVEL_BIT];
    wire [4:0] hold_secs = lock_timing_q[`HOLD_MSB:`HOLD_LSB];
    wire [2:0] win_secs = lock_timing_q[`WIN_MSB:0];

    // code 0 means unused: it never matches
    // first key, second key and external trigger event matches
    wire first_hit = evt_valid && (first_key_code != 7'h00) &&
        (evt_code == first_key_code) && (evt_state == first_key_level);
    wire second_hit = evt_valid && (second_key_code != 7'h00) &&
        (evt_code == second_key_code) && (evt_state == second_key_level);
    wire ext_hit = evt_valid && (guard_trigger_code != 7'h00) &&
        (evt_code == guard_trigger_code) &&
        (evt_state == guard_trigger_level);

    wire is_locked = (state_q != S_OPEN);

    // ****************************************************************
    // bus decode
    // ****************************************************************
    wire wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    wire wr_en = wr_fire && wr_lane_q;
    wire wr_guard = wr_en && (wr_idx_q == `IDX_GUARD_CONFIG);
    wire wr_status = wr_en && (wr_idx_q == `IDX_INT_STATUS);
    wire wr_map_ok = (wr_idx_q == `IDX_UNLOCK_FIRST) ||
        (wr_idx_q == `IDX_UNLOCK_SECOND) ||
        (wr_idx_q == `IDX_EXT_TRIGGER) ||
        (wr_idx_q == `IDX_LOCK_TIMING) ||
        (wr_idx_q == `IDX_GUARD_CONFIG) ||
        (wr_idx_q == `IDX_INT_STATUS) ||
        (wr_idx_q == `IDX_INT_MASK) ||
        (wr_idx_q == `IDX_LOCK_STATE);

    // ****************************************************************
    // timers
    // ****************************************************************
    // one-second time base
    second_tick #(
        .CYCLES(CYCLES_PER_SEC)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_q(tick)
    );

    // hold-off starts on the first event while locked
    wire hold_load = is_locked && evt_valid && (hold_secs != 5'h00) &&
        !hold_run;
    wire hold_clear = (state_d == S_OPEN);

    sec_countdown #(
        .W(5)
    ) u_hold (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .load(hold_load),
        .load_val(hold_secs),
        .clear(hold_clear),
        .running_q(hold_run),
        .expired_q()
    );

    // window armed by the first unlock event
    wire win_load = (state_q == S_LOCKED) && (state_d == S_WAIT2) &&
        (win_secs != 3'h0);
    wire win_clear = (state_d != S_WAIT2);

    sec_countdown #(
        .W(5)
    ) u_win (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .load(win_load),
        .load_val({2'h0, win_secs}),
        .clear(win_clear),
        .running_q(win_run),
        .expired_q(win_exp)
    );

    // ****************************************************************
    // lock sequencing
    // ****************************************************************
    always @* begin
        state_d = state_q;
        status_set = {`ST_W{1'b0}};
        // lock-engaged flag on the external trigger
        if (ext_hit) begin
            status_set[`ST_LOCK] = 1'b1;
        end
        // event interrupt unless hold-off masks it
        if (evt_valid && !(is_locked && hold_run)) begin
            status_set[`ST_EVENT] = 1'b1;
        end
        case (state_q)
            S_OPEN: begin
                if (ext_hit || (wr_guard && wr_byte_q[`LOCK_EN_BIT])) begin
                    state_d = S_LOCKED;
                end
            end
            S_LOCKED: begin
                if (wr_guard && !wr_byte_q[`LOCK_EN_BIT]) begin
                    state_d = S_OPEN;
                end else if (first_hit) begin
                    state_d = S_WAIT2;
                end
            end
            S_WAIT2: begin
                if (wr_guard && !wr_byte_q[`LOCK_EN_BIT]) begin
                    state_d = S_OPEN;
                end else if (second_hit) begin
                    state_d = S_OPEN;
                    status_set[`ST_UNLOCK] = 1'b1;
                // any other event or window expiry relocks
                end else if (evt_valid || win_exp) begin
                    state_d = S_LOCKED;
                    status_set[`ST_FAIL] = 1'b1;
                end
            end
            default: begin
                state_d = S_LOCKED;
            end
        endcase
        // set wins over a write-one clear in the same cycle
        status_d = status_q;
        if (wr_status) begin
            status_d = status_q & ~wr_byte_q[`ST_W-1:0];
        end
        status_d = status_d | status_set;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= S_OPEN;
            locked_q <= 1'b0;
            status_q <= `STAT_RESET;
            irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            locked_q <= (state_d != S_OPEN);
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
        end
    end

    // ****************************************************************
    // software registers
    // ****************************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            unlock_first_q <= `REG_RESET;
            unlock_second_q <= `REG_RESET;
            ext_trigger_q <= `REG_RESET;
            lock_timing_q <= `REG_RESET;
            mask_q <= `STAT_RESET;
        end else if (wr_en) begin
            case (wr_idx_q)
                `IDX_UNLOCK_FIRST: begin
                    unlock_first_q <= wr_byte_q;
                end
                `IDX_UNLOCK_SECOND: begin
                    unlock_second_q <= wr_byte_q;
                end
                `IDX_EXT_TRIGGER: begin
                    ext_trigger_q <= wr_byte_q;
                end
                `IDX_LOCK_TIMING: begin
                    lock_timing_q <= wr_byte_q;
                end
                `IDX_INT_MASK: begin
                    mask_q <= wr_byte_q[`ST_W-1:0];
                end
                default: begin
                    mask_q <= mask_q;
                end
            endcase
        end
    end

    // ****************************************************************
    // axi4-lite write channels
    // ****************************************************************
    // address and data are taken in either order; one write in flight
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            wr_idx_q <= 10'h000;
            wr_byte_q <= 8'h00;
            wr_lane_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_q && !s_axi_awready &&
                !s_axi_bvalid;
            s_axi_wready <= !w_hold_q && !s_axi_wready &&
                !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                wr_idx_q <= s_axi_awaddr[11:2];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wr_byte_q <= s_axi_wdata[7:0];
                wr_lane_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // axi4-lite read channels
    // ****************************************************************
    reg [7:0] rd_byte;
    reg rd_ok;

    always @* begin
        rd_byte = 8'h00;
        rd_ok = 1'b1;
        case (s_axi_araddr[11:2])
            `IDX_UNLOCK_FIRST: begin
                rd_byte = unlock_first_q;
            end
            `IDX_UNLOCK_SECOND: begin
                rd_byte = unlock_second_q;
            end
            `IDX_EXT_TRIGGER: begin
                rd_byte = ext_trigger_q;
            end
            `IDX_LOCK_TIMING: begin
                rd_byte = lock_timing_q;
            end
            `IDX_GUARD_CONFIG: begin
                // enable bit reflects lock mode, rest reads 0
                rd_byte = {7'h00, is_locked};
            end
            `IDX_INT_STATUS: begin
                rd_byte = {4'h0, status_q};
            end
            `IDX_INT_MASK: begin
                rd_byte = {4'h0, mask_q};
            end
            `IDX_LOCK_STATE: begin
                rd_byte = {5'h00, hold_run, win_run, is_locked};
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // keypad_lock_control

// file: hw/keylock_consts.vh
`ifndef KEYLOCK_CONSTS_VH
`define KEYLOCK_CONSTS_VH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define IDX_UNLOCK_FIRST 10'h033
`define IDX_UNLOCK_SECOND 10'h034
`define IDX_EXT_TRIGGER 10'h035
`define IDX_LOCK_TIMING 10'h036
`define IDX_GUARD_CONFIG 10'h037
`define IDX_INT_STATUS 10'h040
`define IDX_INT_MASK 10'h041
`define IDX_LOCK_STATE 10'h042

// ****************************************************************
// field positions
// ****************************************************************
`define CODE_MSB 6
`define LEVEL_BIT 7
`define HOLD_MSB 7
`define HOLD_LSB 3
`define WIN_MSB 2
`define LOCK_EN_BIT 0

// status / mask bits
`define ST_LOCK 0
`define ST_EVENT 1
`define ST_UNLOCK 2
`define ST_FAIL 3
`define ST_W 4

// ****************************************************************
// reset values and responses
// ****************************************************************
`define REG_RESET 8'h00
`define STAT_RESET 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000000000

`endif

// file: hw/second_tick.v
`timescale 1ns/10ps

// one-cycle enable pulse once per CYCLES clocks
module second_tick #(
    parameter CYCLES = 100000000
) (
    input wire aclk,
    input wire aresetn,
    output reg tick_q
);

    localparam integer LAST_I = CYCLES - 1;
    localparam [26:0] LAST = LAST_I[26:0];

    reg [26:0] cnt_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 27'h0000000;
            tick_q <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q <= 27'h0000000;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 27'h0000001;
            tick_q <= 1'b0;
        end
    end

endmodule // second_tick

// file: hw/sec_countdown.v
`timescale 1ns/10ps

// seconds countdown; free-running tick means a load of n lasts
// between n and n+1 seconds, so the time is never short
module sec_countdown #(
    parameter W = 5
) (
    input wire aclk,
    input wire aresetn,
    input wire tick,
    input wire load,
    input wire [W-1:0] load_val,
    input wire clear,
    output reg running_q,
    output reg expired_q
);

    reg [W-1:0] cnt_q;

    always @(posedge aclk) begin
        if (!aresetn || clear) begin
            cnt_q <= {W{1'b0}};
            running_q <= 1'b0;
            expired_q <= 1'b0;
        end else if (load) begin
            cnt_q <= load_val;
            running_q <= 1'b1;
            expired_q <= 1'b0;
        end else begin
            expired_q <= 1'b0;
            if (running_q && tick) begin
                if (cnt_q == {W{1'b0}}) begin
                    running_q <= 1'b0;
                    expired_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // sec_countdown

// file: verif/key_event_src.sv
`timescale 1ns/10ps

// ********************************
// key-scan event source
// ********************************
module key_event_src (
    input wire aclk,
    output logic evt_valid,
    output logic [6:0] evt_code,
    output logic evt_state
);
    initial begin
        evt_valid = 1'b0;
        evt_code = 7'h7f;
        evt_state = 1'b1;
    end

    // code and state are inverted between pulses so a stale
    // value can never pass for a fresh event
    task send(input logic [6:0] code, input logic state);
        @(posedge aclk);
        evt_valid <= 1'b1;
        evt_code <= code;
        evt_state <= state;
        @(posedge aclk);
        evt_valid <= 1'b0;
        evt_code <= ~code;
        evt_state <= ~state;
    endtask
endmodule // key_event_src

// file: verif/keylock_assertions.sv
`timescale 1ns/10ps
`include "keylock_consts.vh"

// ********************************
// port checker
// ********************************
module keylock_assertions (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire evt_valid,
    input wire irq_q,
    input wire locked_q
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    property p_aw_strobe;
        s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_strobe: assert property (p_aw_strobe)
        else $error("awready high two cycles");
    property p_ar_strobe;
        s_axi_arready |=> !s_axi_arready;
    endproperty
    a_ar_strobe: assert property (p_ar_strobe)
        else $error("arready high two cycles");
    property p_b_answer;
        s_wr_taken |-> ##2 s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer)
        else $error("no write response two cycles after request");
    property p_b_one;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_one: assert property (p_b_one)
        else $error("write response not withdrawn after handshake");
    property p_b_resp;
        s_axi_bvalid |-> (s_axi_bresp == `RESP_OKAY)
            || (s_axi_bresp == `RESP_SLVERR);
    endproperty
    a_b_resp: assert property (p_b_resp)
        else $error("illegal write response code");
    property p_r_answer;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("no read data one cycle after request");
    property p_r_upper;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_r_upper: assert property (p_r_upper)
        else $error("read data upper bits not zero");
    // leaving lock takes an event or a register write
    property p_lock_hold;
        locked_q && !evt_valid |=> locked_q || s_axi_bvalid;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lock dropped without event or write");
    // the interrupt only drops after a status or mask write
    property p_irq_fall;
        $fell(irq_q) |-> s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without a write");
endmodule // keylock_assertions

// file: verif/tb_top.sv
`timescale 1ns/10ps

module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic s_axi_rvalid, evt_valid, evt_state, irq_q, locked_q;
    logic [6:0] evt_code;
    int fails = 0;
    int cmp_count = 0;
    // ********************************
    // register rows: write, then read back
    // ********************************
    logic [11:0] r_addr [7] = '{12'h0cc, 12'h0cc, 12'h0d0, 12'h0d4,
        12'h0d8, 12'h104, 12'h3fc};
    logic [31:0] r_data [7] = '{32'hffffff85, 32'h11, 32'h06, 32'h87,
        32'h02, 32'h0f, 32'h55};
    logic [3:0] r_strb [7] = '{4'hf, 4'he, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf};
    logic [31:0] r_exp [7] = '{32'h85, 32'h85, 32'h06, 32'h87, 32'h02,
        32'h0f, 32'h00};
    logic [1:0] r_resp [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};

    always #5 aclk = ~aclk;

    keypad_lock_control #(.CYCLES_PER_SEC(20)) dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .evt_valid, .evt_code, .evt_state,
        .irq_q, .locked_q
    );
    key_event_src src_u (.aclk, .evt_valid, .evt_code, .evt_state);

    task stop_test;
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time,
                seen, exp);
        end
    endtask

    task bit_is(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        #1;
        while (s_axi_awvalid || s_axi_wvalid) begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            #1;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        check({30'h0, s_axi_bresp}, {30'h0, r});
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e,
            input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        check(s_axi_rdata, e);
        check({30'h0, s_axi_rresp}, {30'h0, r});
        s_axi_rready <= 1'b0;
    endtask

    task ev(input logic [6:0] c, input logic s);
        src_u.send(c, s);
        repeat (2) @(posedge aclk);
    endtask

    task clr;
        wr(12'h100, 32'h0f, 4'hf, 2'h0);
    endtask

    initial begin
        #100000;
        fails++;
        stop_test;
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bit_is(locked_q, 1'b0);
        rd(12'h0dc, 32'h0, 2'h0);
        for (int i = 0; i < 7; i++) begin
            wr(r_addr[i], r_data[i], r_strb[i], r_resp[i]);
            rd(r_addr[i], r_exp[i], r_resp[i]);
        end
        ev(7'h07, 1'b0);
        bit_is(locked_q, 1'b0);
        clr;
        ev(7'h07, 1'b1);
        bit_is(locked_q, 1'b1);
        rd(12'h100, 32'h03, 2'h0);
        bit_is(irq_q, 1'b1);
        clr;
        ev(7'h05, 1'b1);
        ev(7'h06, 1'b0);
        bit_is(locked_q, 1'b0);
        rd(12'h100, 32'h06, 2'h0);
        rd(12'h0dc, 32'h0, 2'h0);
        wr(12'h0dc, 32'hff, 4'hf, 2'h0);
        rd(12'h0dc, 32'h01, 2'h0);
        ev(7'h05, 1'b0);
        ev(7'h06, 1'b0);
        bit_is(locked_q, 1'b1);
        ev(7'h05, 1'b1);
        ev(7'h06, 1'b1);
        bit_is(locked_q, 1'b1);
        clr;
        ev(7'h05, 1'b1);
        ev(7'h09, 1'b1);
        ev(7'h06, 1'b0);
        bit_is(locked_q, 1'b1);
        rd(12'h100, 32'h0a, 2'h0);
        // a two second window is 40 to 60 cycles here
        ev(7'h05, 1'b1);
        repeat (100) @(posedge aclk);
        ev(7'h06, 1'b0);
        bit_is(locked_q, 1'b1);
        ev(7'h05, 1'b1);
        rd(12'h108, 32'h03, 2'h0);
        repeat (20) @(posedge aclk);
        ev(7'h06, 1'b0);
        bit_is(locked_q, 1'b0);
        wr(12'h0d8, 32'h00, 4'hf, 2'h0);
        wr(12'h0dc, 32'h01, 4'hf, 2'h0);
        ev(7'h05, 1'b1);
        repeat (200) @(posedge aclk);
        ev(7'h06, 1'b0);
        bit_is(locked_q, 1'b0);
        wr(12'h0d8, 32'h08, 4'hf, 2'h0);
        wr(12'h0dc, 32'h01, 4'hf, 2'h0);
        clr;
        ev(7'h09, 1'b1);
        rd(12'h100, 32'h02, 2'h0);
        clr;
        ev(7'h09, 1'b1);
        rd(12'h100, 32'h00, 2'h0);
        repeat (60) @(posedge aclk);
        ev(7'h09, 1'b1);
        rd(12'h100, 32'h02, 2'h0);
        bit_is(irq_q, 1'b1);
        wr(12'h104, 32'h00, 4'hf, 2'h0);
        repeat (2) @(posedge aclk);
        bit_is(irq_q, 1'b0);
        wr(12'h104, 32'h02, 4'hf, 2'h0);
        repeat (2) @(posedge aclk);
        bit_is(irq_q, 1'b1);
        clr;
        repeat (2) @(posedge aclk);
        bit_is(irq_q, 1'b0);
        wr(12'h0dc, 32'h00, 4'hf, 2'h0);
        bit_is(locked_q, 1'b0);
        wr(12'h0dc, 32'h01, 4'hf, 2'h0);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        bit_is(locked_q, 1'b0);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(12'h0d8, 32'h0, 2'h0);
        stop_test;
    end
endmodule // tb_top

bind keypad_lock_control keylock_assertions chk_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .evt_valid, .irq_q, .locked_q
);
